// *** logic/ext_skip_pkg.sv ***
`default_nettype none
// ==========================================================
// shared constants for the external request skip tests
package ext_skip_pkg;
    // ======================================================
    // register map (byte offsets on the wishbone bus)
    localparam int ADR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] FLAG_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] MASK_OFS = 8'h0c;
    // ======================================================
    // field positions
    localparam int EXT0_BIT = 0;
    localparam int EXT1_BIT = 1;
    localparam int SUPP_BIT = 2;
    localparam int CTRL_W = 2;
    localparam int EVT_W = 3;
    // ======================================================
    // reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [2:0] STAT_RST = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;
    // ======================================================
    // instruction word
    localparam int INSTR_W = 10;
    localparam logic [9:0] OPC_SKIP_EXT0 = 10'h03a;
    localparam logic [9:0] OPC_SKIP_EXT1 = 10'h03b;
endpackage : ext_skip_pkg
`default_nettype wire

// *** logic/flag_skip_unit.sv ***
`default_nettype none
// ==========================================================
// one request flag with its skip test
module flag_skip_unit (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic set_req,
    input wire logic test_strobe,
    input wire logic enable_bit,
    output logic flag,
    output logic skip
);
    logic next_flag;

    always_comb begin
        skip = test_strobe & ~enable_bit & flag; // RULE3 RULE7
        // a request arriving with the clear is kept
        if (set_req) begin
            next_flag = 1'b1;
        end else if (skip) begin
            next_flag = 1'b0; // RULE1 RULE6
        end else begin
            next_flag = flag;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

    set_wins_a: assert property (@(posedge clk) disable iff (!rst_b)
        set_req |=> flag)
        else $error("request lost while clearing flag");
endmodule : flag_skip_unit
`default_nettype wire

// *** logic/ext_irq_flag_skip_test.sv ***
// Functional notes
// RULE1: enable0 low and flag0 set: ext0 test skips next word, clears flag0.
// RULE2: flag0 clear: ext0 test does not skip; next word executes.
// RULE3: enable0 high: ext0 test is a nop, flag0 untouched.
// RULE4: enable0 is bit 0 of the interrupt control register.
// RULE5: enable1 low and flag1 set: ext1 test skips the next word.
// RULE6: ext1 test clears flag1 after skipping; flag1 clear means no skip.
// RULE7: enable1 is bit 1 of control register; high makes ext1 test a nop.
// RULE8: tests are one word; skipped word is fetched, suppressed, no effect.
`default_nettype none
module ext_irq_flag_skip_test #(
    parameter int INSTR_W = ext_skip_pkg::INSTR_W,
    parameter logic [9:0] OPC0 = ext_skip_pkg::OPC_SKIP_EXT0,
    parameter logic [9:0] OPC1 = ext_skip_pkg::OPC_SKIP_EXT1
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [ext_skip_pkg::ADR_W-1:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic INSTR_VALID,
    input wire logic [INSTR_W-1:0] INSTR_WORD,
    input wire logic EXT0_REQ_SET,
    input wire logic EXT1_REQ_SET,
    output logic RETIRE,
    output logic HANDLED,
    output logic SKIP_TAKEN,
    output logic SUPPRESSED,
    output logic EXT0_REQ_FLAG,
    output logic EXT1_REQ_FLAG,
    output logic IRQ
);
    import ext_skip_pkg::*;

    typedef enum logic {ST_EXEC, ST_SUPPRESS} state_t;

    state_t state;
    state_t next_state;
    logic [CTRL_W-1:0] ctrl;
    logic [CTRL_W-1:0] next_ctrl;
    logic [EVT_W-1:0] stat;
    logic [EVT_W-1:0] next_stat;
    logic [EVT_W-1:0] mask;
    logic [EVT_W-1:0] next_mask;
    logic next_irq;
    logic next_ack;
    logic [31:0] next_dat;
    logic next_retire;
    logic next_handled;
    logic next_skip;
    logic next_supp;
    logic wr_stb;
    logic exec_word;
    logic test0;
    logic test1;
    logic skip0;
    logic skip1;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] w1c;

    function automatic logic hit(input logic [ADR_W-1:0] adr,
                                 input logic [ADR_W-1:0] ofs);
        hit = (adr[ADR_W-1:2] == ofs[ADR_W-1:2]);
    endfunction : hit

    // ======================================================
    // request flags with their skip tests
    flag_skip_unit u_ext0 (
        .clk(CLK),
        .rst_b(RST_B),
        .set_req(EXT0_REQ_SET),
        .test_strobe(test0),
        .enable_bit(ctrl[EXT0_BIT]), // RULE3 RULE4
        .flag(EXT0_REQ_FLAG),
        .skip(skip0)
    );

    flag_skip_unit u_ext1 (
        .clk(CLK),
        .rst_b(RST_B),
        .set_req(EXT1_REQ_SET),
        .test_strobe(test1),
        .enable_bit(ctrl[EXT1_BIT]), // RULE7
        .flag(EXT1_REQ_FLAG),
        .skip(skip1)
    );

    // ======================================================
    // instruction stream
    always_comb begin
        exec_word = INSTR_VALID & (state == ST_EXEC);
        test0 = exec_word & (INSTR_WORD == OPC0[INSTR_W-1:0]); // RULE1
        test1 = exec_word & (INSTR_WORD == OPC1[INSTR_W-1:0]); // RULE5
        next_retire = exec_word; // RULE8
        next_handled = test0 | test1;
        next_skip = skip0 | skip1; // RULE2
        next_supp = INSTR_VALID & (state == ST_SUPPRESS); // RULE8
        case (state)
            ST_EXEC: begin
                next_state = (skip0 | skip1) ? ST_SUPPRESS : ST_EXEC;
            end
            ST_SUPPRESS: begin
                next_state = INSTR_VALID ? ST_EXEC : ST_SUPPRESS;
            end
            default: begin
                next_state = ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            state <= ST_EXEC;
            RETIRE <= 1'b0;
            HANDLED <= 1'b0;
            SKIP_TAKEN <= 1'b0;
            SUPPRESSED <= 1'b0;
        end else begin
            state <= next_state;
            RETIRE <= next_retire;
            HANDLED <= next_handled;
            SKIP_TAKEN <= next_skip;
            SUPPRESSED <= next_supp;
        end
    end

    // ======================================================
    // wishbone registers and interrupt
    always_comb begin
        next_ack = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
        wr_stb = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O;
        next_ctrl = ctrl;
        next_mask = mask;
        w1c = '0;
        if (wr_stb && WB_SEL_I[0]) begin
            if (hit(WB_ADR_I, CTRL_OFS)) begin
                next_ctrl = WB_DAT_I[CTRL_W-1:0]; // RULE4 RULE7
            end
            if (hit(WB_ADR_I, MASK_OFS)) begin
                next_mask = WB_DAT_I[EVT_W-1:0];
            end
            if (hit(WB_ADR_I, STAT_OFS)) begin
                w1c = WB_DAT_I[EVT_W-1:0];
            end
        end
        evt = '0;
        evt[EXT0_BIT] = skip0;
        evt[EXT1_BIT] = skip1;
        evt[SUPP_BIT] = next_supp;
        next_stat = (stat & ~w1c) | evt;
        next_irq = |(next_stat & next_mask);
        next_dat = '0;
        if (hit(WB_ADR_I, CTRL_OFS)) begin
            next_dat[CTRL_W-1:0] = ctrl;
        end else if (hit(WB_ADR_I, FLAG_OFS)) begin
            next_dat[EXT0_BIT] = EXT0_REQ_FLAG;
            next_dat[EXT1_BIT] = EXT1_REQ_FLAG;
        end else if (hit(WB_ADR_I, STAT_OFS)) begin
            next_dat[EVT_W-1:0] = stat;
        end else if (hit(WB_ADR_I, MASK_OFS)) begin
            next_dat[EVT_W-1:0] = mask;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ctrl <= CTRL_RST;
            stat <= STAT_RST;
            mask <= MASK_RST;
            IRQ <= 1'b0;
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end else begin
            ctrl <= next_ctrl;
            stat <= next_stat;
            mask <= next_mask;
            IRQ <= next_irq;
            WB_ACK_O <= next_ack;
            WB_DAT_O <= next_dat;
        end
    end

    // ======================================================
    // checks
    skip0_taken_a: assert property (@(posedge CLK) // RULE1
        disable iff (!RST_B)
        test0 && !ctrl[EXT0_BIT] && EXT0_REQ_FLAG
        |=> SKIP_TAKEN && state == ST_SUPPRESS)
        else $error("ext0 test did not skip");

    flag0_clear_a: assert property (@(posedge CLK) // RULE1
        disable iff (!RST_B)
        test0 && !ctrl[EXT0_BIT] && !EXT0_REQ_SET
        |=> !EXT0_REQ_FLAG)
        else $error("ext0 flag not cleared after skip");

    noskip0_a: assert property (@(posedge CLK) disable iff (!RST_B) // RULE2
        test0 && !EXT0_REQ_FLAG |=> !SKIP_TAKEN ##1 !SUPPRESSED)
        else $error("ext0 test skipped with flag clear");

    nop0_a: assert property (@(posedge CLK) disable iff (!RST_B) // RULE3
        test0 && ctrl[EXT0_BIT] && EXT0_REQ_FLAG
        |=> EXT0_REQ_FLAG && !SKIP_TAKEN && state == ST_EXEC)
        else $error("ext0 test not a nop while enabled");

    ctrl_bits_a: assert property (@(posedge CLK) disable iff (!RST_B) // RULE4
        wr_stb && WB_SEL_I[0] && hit(WB_ADR_I, CTRL_OFS)
        |=> ctrl[EXT0_BIT] == $past(WB_DAT_I[EXT0_BIT])
            && ctrl[EXT1_BIT] == $past(WB_DAT_I[EXT1_BIT]))
        else $error("control bits not taken from data");

    skip1_taken_a: assert property (@(posedge CLK) // RULE5
        disable iff (!RST_B)
        test1 && !ctrl[EXT1_BIT] && EXT1_REQ_FLAG
        |=> SKIP_TAKEN && stat[EXT1_BIT])
        else $error("ext1 test did not skip");

    flag1_clear_a: assert property (@(posedge CLK) // RULE6
        disable iff (!RST_B)
        test1 && !ctrl[EXT1_BIT] && !EXT1_REQ_SET
        |=> !EXT1_REQ_FLAG)
        else $error("ext1 flag not cleared");

    nop1_a: assert property (@(posedge CLK) disable iff (!RST_B) // RULE7
        test1 && ctrl[EXT1_BIT] && !EXT1_REQ_SET
        |=> $stable(EXT1_REQ_FLAG) && !SKIP_TAKEN && HANDLED)
        else $error("ext1 test changed flag while enabled");

    suppress_word_a: assert property (@(posedge CLK) // RULE8
        disable iff (!RST_B)
        SKIP_TAKEN ##0 INSTR_VALID
        |=> SUPPRESSED && !RETIRE && !HANDLED && state == ST_EXEC)
        else $error("skipped word not suppressed");

    ack_one_a: assert property (@(posedge CLK) disable iff (!RST_B)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held for more than one cycle");

    noskip1_a: assert property (@(posedge CLK) disable iff (!RST_B) // RULE6
        test1 && !EXT1_REQ_FLAG |=> !SKIP_TAKEN ##1 !SUPPRESSED)
        else $error("ext1 test skipped with flag clear");

    nop0_flag_a: assert property (@(posedge CLK) disable iff (!RST_B) // RULE3
        test0 && ctrl[EXT0_BIT] && !EXT0_REQ_SET
        |=> $stable(EXT0_REQ_FLAG) && !SKIP_TAKEN && HANDLED)
        else $error("ext0 test altered state while enabled");

    retire_word_a: assert property (@(posedge CLK) // RULE8
        disable iff (!RST_B)
        exec_word |=> RETIRE && !SUPPRESSED)
        else $error("executed word not retired");

    handled_test_a: assert property (@(posedge CLK) // RULE8
        disable iff (!RST_B)
        (test0 || test1) |=> HANDLED && RETIRE)
        else $error("flag test not reported as handled");

    skip_wait_a: assert property (@(posedge CLK) // RULE8
        disable iff (!RST_B)
        state == ST_SUPPRESS && !INSTR_VALID
        |=> state == ST_SUPPRESS && !RETIRE && !SUPPRESSED)
        else $error("pending skip lost before next word");

    supp_status_a: assert property (@(posedge CLK) // RULE8
        disable iff (!RST_B)
        SUPPRESSED |-> stat[SUPP_BIT])
        else $error("suppressed word not logged in status");

    flag0_quiet_a: assert property (@(posedge CLK) disable iff (!RST_B)
        !EXT0_REQ_FLAG && !EXT0_REQ_SET |=> !EXT0_REQ_FLAG)
        else $error("ext0 flag rose without a request");

    flag1_quiet_a: assert property (@(posedge CLK) disable iff (!RST_B)
        !EXT1_REQ_FLAG && !EXT1_REQ_SET |=> !EXT1_REQ_FLAG)
        else $error("ext1 flag rose without a request");

    // ======================================================
    // bus and interrupt checks
    ack_answer_a: assert property (@(posedge CLK) disable iff (!RST_B)
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("bus request not answered next cycle");

    flag_read_a: assert property (@(posedge CLK) disable iff (!RST_B)
        WB_CYC_I && WB_STB_I && !WB_ACK_O && hit(WB_ADR_I, FLAG_OFS)
        |=> WB_DAT_O[EXT0_BIT] == $past(EXT0_REQ_FLAG)
            && WB_DAT_O[EXT1_BIT] == $past(EXT1_REQ_FLAG))
        else $error("flag read data wrong");

    irq_level_a: assert property (@(posedge CLK) disable iff (!RST_B)
        IRQ == |(stat & mask))
        else $error("interrupt not following status and mask");

    stat_sticky_a: assert property (@(posedge CLK) disable iff (!RST_B)
        !(wr_stb && WB_SEL_I[0] && hit(WB_ADR_I, STAT_OFS))
        |=> (stat & $past(stat)) == $past(stat))
        else $error("status bit cleared without a write");

    ctrl_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
        !(wr_stb && WB_SEL_I[0] && hit(WB_ADR_I, CTRL_OFS))
        |=> $stable(ctrl))
        else $error("control changed without a write");
endmodule : ext_irq_flag_skip_test
`default_nettype wire

// *** testbench/test_ext_irq_flag_skip_test.sv ***
`default_nettype none
module test_ext_irq_flag_skip_test;
    timeunit 1ns;
    timeprecision 1ns;
    import ext_skip_pkg::*;
    logic clk = 0;
    logic rst_b = 0;
    logic cyc = 0;
    logic stb = 0;
    logic we = 0;
    logic [7:0] adr = '0;
    logic [31:0] wdat = '0;
    logic ivalid = 0;
    logic [9:0] iword = '0;
    logic set0 = 0;
    logic set1 = 0;
    logic [31:0] rdat;
    logic ack, ret, hand, skp, supp, f0, f1, irq;
    int errors = 0;
    int total_checks = 0;
    int seed = 21419;
    logic chk = 0;
    // ==========================================================
    // reference model state
    logic [1:0] m_ctrl = '0;
    logic [1:0] m_flag = '0;
    logic [2:0] m_stat = '0;
    logic [2:0] m_mask = '0;
    logic m_ack = 0, m_pend = 0, m_ret = 0, m_hand = 0, m_skip = 0;
    logic m_supp = 0;
    logic [31:0] m_rdat = '0;
    logic [7:0] mreg_adrs [5] = '{CTRL_OFS, FLAG_OFS, STAT_OFS, MASK_OFS,
                                  8'h10};

    always #10 clk = ~clk;

    ext_irq_flag_skip_test uut (.CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wdat),
        .WB_SEL_I(4'hf), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .INSTR_VALID(ivalid), .INSTR_WORD(iword), .EXT0_REQ_SET(set0),
        .EXT1_REQ_SET(set1), .RETIRE(ret), .HANDLED(hand),
        .SKIP_TAKEN(skp), .SUPPRESSED(supp), .EXT0_REQ_FLAG(f0),
        .EXT1_REQ_FLAG(f1), .IRQ(irq));

    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task summarize;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    function logic [31:0] mreg(input logic [7:0] a);
        case (a)
            CTRL_OFS: return 32'(m_ctrl);
            FLAG_OFS: return 32'(m_flag);
            STAT_OFS: return 32'(m_stat);
            MASK_OFS: return 32'(m_mask);
            default: return '0;
        endcase
    endfunction : mreg

    // ==========================================================
    // model updated at every edge from inputs before they change
    always @(posedge clk) begin : mdl
        logic [2:0] ev;
        logic [1:0] clr;
        logic wr;
        ev = '0;
        clr = '0;
        wr = cyc & stb & we & m_ack;
        // read data is taken from the registers at the request edge
        if (rst_b && cyc && stb && !m_ack) m_rdat = mreg(adr);
        m_ack = rst_b & cyc & stb & ~m_ack;
        {m_ret, m_hand, m_skip, m_supp} = '0;
        if (rst_b && ivalid) begin
            if (m_pend) begin
                m_supp = 1;
                m_pend = 0;
                ev[2] = 1;
            end else begin
                m_ret = 1;
                for (int k = 0; k < 2; k++) begin
                    if (iword == (k ? OPC_SKIP_EXT1 : OPC_SKIP_EXT0)) begin
                        m_hand = 1;
                        if (!m_ctrl[k] && m_flag[k]) begin
                            m_skip = 1;
                            m_pend = 1;
                            clr[k] = 1;
                            ev[k] = 1;
                        end
                    end
                end
            end
        end
        m_flag = (m_flag & ~clr) | {set1, set0};
        if (wr && adr == STAT_OFS) m_stat = m_stat & ~wdat[2:0];
        m_stat = m_stat | ev;
        if (wr && adr == CTRL_OFS) m_ctrl = wdat[1:0];
        if (wr && adr == MASK_OFS) m_mask = wdat[2:0];
        if (!rst_b) {m_ctrl, m_flag, m_stat, m_mask, m_pend} = '0;
    end

    always @(negedge clk) begin
        if (chk) begin
            check("ack", ack, m_ack);
            check("retire", ret, m_ret);
            check("handled", hand, m_hand);
            check("skip", skp, m_skip);
            check("suppressed", supp, m_supp);
            check("flag0", f0, m_flag[0]);
            check("flag1", f1, m_flag[1]);
            check("irq", irq, |(m_stat & m_mask));
        end
    end

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(negedge clk);
        while (ack !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (n >= 20) begin
            errors++;
            summarize();
        end
        if (!w) check("read data", rdat, m_rdat);
        @(posedge clk);
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask : wb

    task ins(input logic v, input logic [9:0] w, input logic s0,
             input logic s1);
        @(posedge clk);
        ivalid <= v;
        iword <= w;
        set0 <= s0;
        set1 <= s1;
    endtask : ins

    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        summarize();
    end

    initial begin
        int r;
        repeat (6) @(posedge clk);
        rst_b <= 1;
        chk <= 1;
        foreach (mreg_adrs[i]) wb(0, mreg_adrs[i], '0);
        wb(1, MASK_OFS, 32'h0000_0007);
        // every enable setting: bit positions and nop behaviour
        for (int c = 0; c < 4; c++) begin
            wb(1, CTRL_OFS, 32'(c));
            ins(0, '0, 1, 1);
            ins(1, OPC_SKIP_EXT0, 1, 0);
            ins(1, 10'h155, 0, 0);
            ins(1, OPC_SKIP_EXT0, 0, 0);
            ins(1, OPC_SKIP_EXT1, 0, 0);
            ins(1, OPC_SKIP_EXT1, 0, 0);
            ins(1, OPC_SKIP_EXT1, 0, 0);
            ins(0, '0, 0, 0);
            wb(0, FLAG_OFS, '0);
            wb(0, STAT_OFS, '0);
            wb(1, STAT_OFS, 32'h0000_0007);
            wb(0, STAT_OFS, '0);
        end
        // reset in mid-run with both flags pending
        ins(0, '0, 1, 1);
        ins(0, '0, 0, 0);
        rst_b <= 0;
        repeat (2) @(posedge clk);
        rst_b <= 1;
        foreach (mreg_adrs[i]) wb(0, mreg_adrs[i], '0);
        repeat (4) begin
            r = $random(seed);
            wb(1, CTRL_OFS, 32'(r[1:0]));
            wb(1, MASK_OFS, 32'(r[4:2]));
            repeat (60) begin
                r = $random(seed);
                ins(r[0] | r[3], r[1] ? (r[2] ? OPC_SKIP_EXT1 : OPC_SKIP_EXT0)
                    : r[15:6], r[4] & r[5], r[16] & r[17]);
            end
            ins(0, '0, 0, 0);
            wb(0, STAT_OFS, '0);
            wb(1, STAT_OFS, 32'(r[22:20]));
            wb(0, STAT_OFS, '0);
        end
        summarize();
    end
endmodule : test_ext_irq_flag_skip_test
`default_nettype wire
